//--- verilog/mcc_params.svh
// Purpose: Constants for the machine-cycle clock control block.
// Assumes: One core clock at 200 MHz, APB register access.
// Notes: Offsets are byte addresses of 32-bit registers.
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH
`define MCC_OFF_CTRL 12'h000
`define MCC_OFF_STAT 12'h004
`define MCC_OFF_IRQ_STAT 12'h008
`define MCC_OFF_IRQ_CLR 12'h00C
`define MCC_OFF_IRQ_EN 12'h010
`define MCC_FAST_CLKS 11'd4
`define MCC_SLOW_CLKS 11'd1024
`define MCC_TMR_SLOW 4'd12
`define MCC_TMR_FAST 4'd4
`define MCC_CTRL_RST 32'h0000_0000
`define MCC_B_LOWRATE 0
`define MCC_B_AUTOSW 1
`define MCC_B_TMRFAST 2
`define MCC_B_MUL_LO 3
`define MCC_B_IDLE 5
`define MCC_B_STOP 6
`define MCC_B_PFRST_EN 7
`endif

//--- verilog/mcc_pkg.sv
// Purpose: Types for the machine-cycle clock control block.
// Assumes: Included constants header.
// Notes: Carries cycle outputs as one struct.
package mcc_pkg;
	typedef enum logic [1:0] {
		MCC_RUN,
		MCC_IDLE,
		MCC_STOP
	} mcc_pstate_t;
	typedef struct packed {
		logic ale;
		logic cyc_end;
		logic tmr_tick;
	} mcc_cyc_t;
endpackage

//--- verilog/mcc_machine_cycle_clock_control.sv
// Purpose: Machine-cycle timing, timer tick, power states and power fail.
// Assumes: External events and supply flag are asynchronous pins.
// Notes: Registers are reached over APB with one wait state.
`timescale 1ns/1ps
`include "mcc_params.svh"
module mcc_machine_cycle_clock_control
	import mcc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic wake_i,
	input wire logic ext_int_i,
	input wire logic serial_act_i,
	input wire logic supply_low_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic ale_o,
	output logic cyc_end_o,
	output logic tmr_tick_o,
	output logic [1:0] clk_mul_o,
	output logic cpu_idle_o,
	output logic clk_stop_o,
	output logic pf_reset_o,
	output logic irq_o
);
	logic [2:0] sa_q, sb_q;
	logic sup_a_q, sup_b_q, sup_c_q;
	logic [31:0] ctrl_q, ctrl_d;
	logic [1:0] ist_q, ist_d, ien_q, ien_d;
	logic low_rate_cycle_mode_q, low_rate_cycle_mode_d;
	logic [10:0] cnt_q, cnt_d;
	logic [3:0] tcnt_q, tcnt_d;
	mcc_pstate_t ps_q, ps_d;
	mcc_cyc_t cyc_q, cyc_d;
	logic [31:0] rd_q, rd_d;
	logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d, pfr_q, pfr_d;
	logic idle_q, idle_d, stop_q, stop_d, stall_q, stall_d;
	logic acc, wr, sw_evt, wake_s, pf_s, boundary, low_next;
	logic [10:0] len;
	logic [10:0] gap_q, gap_d;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sa_q <= 3'h0;
			sb_q <= 3'h0;
			sup_a_q <= 1'b0;
			sup_b_q <= 1'b0;
			sup_c_q <= 1'b0;
		end else begin
			sa_q <= {wake_i, serial_act_i, ext_int_i};
			sb_q <= sa_q;
			sup_a_q <= supply_low_i;
			sup_b_q <= sup_a_q;
			sup_c_q <= sup_b_q;
		end
	end

	assign acc = psel_i && penable_i;
	assign wr = acc && pwrite_i && rdy_q;
	assign sw_evt = sb_q[0] || sb_q[1];
	assign wake_s = sb_q[2] || sw_evt;
	assign pf_s = sup_b_q && !sup_c_q;
	assign len = low_rate_cycle_mode_q ? `MCC_SLOW_CLKS : `MCC_FAST_CLKS;
	assign boundary = (cnt_q == len - 11'd1);

	always_comb begin
		ctrl_d = ctrl_q;
		ien_d = ien_q;
		ist_d = ist_q;
		rd_d = rd_q;
		err_d = 1'b0;
		rdy_d = acc && !rdy_q;
		if (wr && hit(paddr_i, `MCC_OFF_CTRL)) begin
			ctrl_d = pwdata_i;
		end
		if (wr && hit(paddr_i, `MCC_OFF_IRQ_EN)) begin
			ien_d = pwdata_i[1:0];
		end
		if (wr && hit(paddr_i, `MCC_OFF_IRQ_CLR)) begin
			ist_d = ist_q & ~pwdata_i[1:0];
		end
		if (pf_s) begin
			ist_d[0] = 1'b1;
		end
		if (sw_evt && low_rate_cycle_mode_q && ctrl_q[`MCC_B_AUTOSW]) begin
			ist_d[1] = 1'b1;
		end
		if (ps_q != MCC_RUN && wake_s) begin
			ctrl_d[`MCC_B_IDLE] = 1'b0;
			ctrl_d[`MCC_B_STOP] = 1'b0;
		end
		if (ctrl_q[`MCC_B_AUTOSW] && sw_evt) begin
			ctrl_d[`MCC_B_LOWRATE] = 1'b0;
		end
		if (acc && !rdy_q && !pwrite_i) begin
			case (paddr_i)
				`MCC_OFF_CTRL: rd_d = ctrl_q;
				`MCC_OFF_STAT: rd_d = {28'h0, pfr_q, sup_b_q,
					ps_q != MCC_RUN, low_rate_cycle_mode_q};
				`MCC_OFF_IRQ_STAT: rd_d = {30'h0, ist_q};
				`MCC_OFF_IRQ_CLR: rd_d = 32'h0;
				`MCC_OFF_IRQ_EN: rd_d = {30'h0, ien_q};
				default: begin
					rd_d = 32'h0;
					err_d = 1'b1;
				end
			endcase
		end else if (acc && !rdy_q) begin
			err_d = !(hit(paddr_i, `MCC_OFF_CTRL) ||
				hit(paddr_i, `MCC_OFF_IRQ_CLR) ||
				hit(paddr_i, `MCC_OFF_IRQ_EN));
		end
		irq_d = |(ist_d & ien_d);
	end

	assign low_next = ctrl_q[`MCC_B_LOWRATE] &&
		!(ctrl_q[`MCC_B_AUTOSW] && sw_evt);

	always_comb begin
		cnt_d = cnt_q;
		tcnt_d = tcnt_q;
		low_rate_cycle_mode_d = low_rate_cycle_mode_q;
		ps_d = ps_q;
		cyc_d = '0;
		pfr_d = pfr_q;
		if (ps_q != MCC_STOP) begin
			if (boundary) begin
				cnt_d = 11'd0;
				low_rate_cycle_mode_d = low_next;
			end else begin
				cnt_d = cnt_q + 11'd1;
			end
			cyc_d.ale = (cnt_q == 11'd0);
			cyc_d.cyc_end = boundary;
			if (tcnt_q == (ctrl_q[`MCC_B_TMRFAST] ? `MCC_TMR_FAST
				: `MCC_TMR_SLOW) - 4'd1) begin
				tcnt_d = 4'd0;
				cyc_d.tmr_tick = 1'b1;
			end else begin
				tcnt_d = tcnt_q + 4'd1;
			end
		end
		case (ps_q)
			MCC_RUN: begin
				if (ctrl_q[`MCC_B_STOP] && boundary) begin
					ps_d = MCC_STOP;
				end else if (ctrl_q[`MCC_B_IDLE] && boundary) begin
					ps_d = MCC_IDLE;
				end
			end
			MCC_IDLE, MCC_STOP: begin
				if (wake_s) begin
					ps_d = MCC_RUN;
				end
			end
			default: ps_d = MCC_RUN;
		endcase
		pfr_d = ctrl_q[`MCC_B_PFRST_EN] && sup_b_q;
		idle_d = (ps_d == MCC_IDLE);
		stop_d = (ps_d == MCC_STOP);
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= `MCC_CTRL_RST;
			ien_q <= 2'h0;
			ist_q <= 2'h0;
			rd_q <= 32'h0;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
			cnt_q <= 11'd0;
			tcnt_q <= 4'd0;
			low_rate_cycle_mode_q <= 1'b0;
			ps_q <= MCC_RUN;
			cyc_q <= '0;
			pfr_q <= 1'b0;
			idle_q <= 1'b0;
			stop_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ien_q <= ien_d;
			ist_q <= ist_d;
			rd_q <= rd_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
			irq_q <= irq_d;
			cnt_q <= cnt_d;
			tcnt_q <= tcnt_d;
			low_rate_cycle_mode_q <= low_rate_cycle_mode_d;
			ps_q <= ps_d;
			cyc_q <= cyc_d;
			pfr_q <= pfr_d;
			idle_q <= idle_d;
			stop_q <= stop_d;
		end
	end

	assign prdata_o = rd_q;
	assign pready_o = rdy_q;
	assign pslverr_o = err_q;
	assign ale_o = cyc_q.ale;
	assign cyc_end_o = cyc_q.cyc_end;
	assign tmr_tick_o = cyc_q.tmr_tick;
	assign clk_mul_o = ctrl_q[`MCC_B_MUL_LO+1:`MCC_B_MUL_LO];
	assign cpu_idle_o = idle_q;
	assign clk_stop_o = stop_q;
	assign pf_reset_o = pfr_q;
	assign irq_o = irq_q;

	// Counts clocks between strobes and notes any stop in between.
	always_comb begin
		gap_d = gap_q;
		stall_d = stall_q || clk_stop_o;
		if (ale_o) begin
			gap_d = 11'h001;
			stall_d = 1'b0;
		end else if (gap_q != 11'h7FF) begin
			gap_d = gap_q + 11'h001;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gap_q <= 11'h000;
			stall_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			stall_q <= stall_d;
		end
	end

	property p_fast_len;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ale_o && !low_rate_cycle_mode_q)
			|=> !ale_o [*3] ##1 (ale_o || $past(clk_stop_o));
	endproperty
	a_fast_len: assert property (p_fast_len)
		else $error("Fast machine cycle is not four clocks.");

	property p_one_ale;
		@(posedge core_clk_i) disable iff (!resetn_i)
		ale_o |=> !ale_o;
	endproperty
	a_one_ale: assert property (p_one_ale)
		else $error("Address strobe lasts more than one clock.");

	property p_boundary;
		@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(low_rate_cycle_mode_q) |-> cnt_q == 11'd0;
	endproperty
	a_boundary: assert property (p_boundary)
		else $error("Rate changed inside a machine cycle.");

	property p_autosw;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ctrl_q[`MCC_B_AUTOSW] && sw_evt) |=> !ctrl_q[`MCC_B_LOWRATE];
	endproperty
	a_autosw: assert property (p_autosw)
		else $error("Switchback did not clear low-rate mode.");

	property p_slow;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(low_rate_cycle_mode_q && cnt_q == 11'd4) |-> !boundary;
	endproperty
	a_slow: assert property (p_slow)
		else $error("Low-rate cycle ended too early.");

	property p_tick;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(tmr_tick_o && !ctrl_q[`MCC_B_TMRFAST] && ps_q != MCC_STOP)
			|=> !tmr_tick_o [*3];
	endproperty
	a_tick: assert property (p_tick)
		else $error("Slow timer tick came too soon.");

	property p_tick4;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(tcnt_q == 4'd3 && ctrl_q[`MCC_B_TMRFAST] && ps_q != MCC_STOP)
			|=> tmr_tick_o;
	endproperty
	a_tick4: assert property (p_tick4)
		else $error("Fast timer tick missing.");

	property p_stop;
		@(posedge core_clk_i) disable iff (!resetn_i)
		clk_stop_o |=> !ale_o;
	endproperty
	a_stop: assert property (p_stop)
		else $error("Strobe while clocks stopped.");

	property p_pf;
		@(posedge core_clk_i) disable iff (!resetn_i)
		pf_s |=> ist_q[0];
	endproperty
	a_pf: assert property (p_pf)
		else $error("Power-fail warning not flagged.");

	property p_slow_len;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ale_o && $past(low_rate_cycle_mode_q, 2) && !stall_q)
			|-> gap_q == `MCC_SLOW_CLKS;
	endproperty
	a_slow_len: assert property (p_slow_len)
		else $error("Low-rate machine cycle is not 1024 clocks.");

	property p_cyc_end;
		@(posedge core_clk_i) disable iff (!resetn_i)
		cyc_end_o |=> ale_o || $past(clk_stop_o);
	endproperty
	a_cyc_end: assert property (p_cyc_end)
		else $error("No strobe after the end of a machine cycle.");

	property p_tick12;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(tcnt_q == 4'hB && !ctrl_q[`MCC_B_TMRFAST] && ps_q != MCC_STOP)
			|=> tmr_tick_o;
	endproperty
	a_tick12: assert property (p_tick12)
		else $error("Slow timer tick missing.");

	property p_wake;
		@(posedge core_clk_i) disable iff (!resetn_i)
		((cpu_idle_o || clk_stop_o) && wake_s)
			|=> !(cpu_idle_o || clk_stop_o);
	endproperty
	a_wake: assert property (p_wake)
		else $error("Wake event did not resume the core.");

	property p_idle;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ps_q == MCC_RUN && ctrl_q[`MCC_B_IDLE] && !ctrl_q[`MCC_B_STOP] &&
			boundary) |=> cpu_idle_o;
	endproperty
	a_idle: assert property (p_idle)
		else $error("Idle request not taken at the cycle end.");

	property p_pf_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(pf_s && ien_q[0] && !(wr && hit(paddr_i, `MCC_OFF_IRQ_EN)))
			|=> irq_o;
	endproperty
	a_pf_irq: assert property (p_pf_irq)
		else $error("Enabled power-fail warning did not interrupt.");
endmodule

//--- testbench/mcc_core_model.sv
// Purpose: Core-side model that watches strobe and timer tick spacing.
// Assumes: Strobes are one-cycle pulses in the core clock domain.
// Notes: Each gap is the clock count between two successive pulses.
`timescale 1ns/1ps
module mcc_core_model (
	input wire logic core_clk_i,
	input wire logic ale_i,
	input wire logic tick_i,
	output int ale_gap_o,
	output int tick_gap_o
);
	int ale_cnt = 0;
	int tick_cnt = 0;
	// The core counts clocks per machine cycle and per timer increment.
	always @(posedge core_clk_i) begin
		ale_cnt <= ale_i ? 1 : ale_cnt + 1;
		tick_cnt <= tick_i ? 1 : tick_cnt + 1;
		if (ale_i) begin
			ale_gap_o <= ale_cnt;
		end
		if (tick_i) begin
			tick_gap_o <= tick_cnt;
		end
	end
endmodule

//--- testbench/tb_machine_cycle_clock_control.sv
// Purpose: Self-checking bench for the machine-cycle clock control block.
// Assumes: APB read data and error are taken at the edge with pready high.
// Notes: Strobe and tick spacing are measured by the core model.
`timescale 1ns/1ps
`include "mcc_params.svh"
module tb_machine_cycle_clock_control;
	logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic wake = 0, ext_int = 0, serial_act = 0, supply_low = 0;
	logic pready, pslverr, ale, cyc_end, tmr_tick, cpu_idle, clk_stop;
	logic pf_reset, irq, e;
	logic [1:0] clk_mul;
	int ale_gap, tick_gap, fail_count = 0, samples_checked = 0, cycles = 0;
	always #2.5 core_clk = ~core_clk;
	mcc_machine_cycle_clock_control dut (.core_clk_i(core_clk),
		.resetn_i(resetn), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.wake_i(wake), .ext_int_i(ext_int), .serial_act_i(serial_act),
		.supply_low_i(supply_low), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ale_o(ale), .cyc_end_o(cyc_end),
		.tmr_tick_o(tmr_tick), .clk_mul_o(clk_mul), .cpu_idle_o(cpu_idle),
		.clk_stop_o(clk_stop), .pf_reset_o(pf_reset), .irq_o(irq));
	mcc_core_model core (.core_clk_i(core_clk), .ale_i(ale),
		.tick_i(tmr_tick), .ale_gap_o(ale_gap), .tick_gap_o(tick_gap));
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic t_default;
		apb(0, `MCC_OFF_CTRL, 32'h0);
		chk(r, `MCC_CTRL_RST);
		cyc(40);
		chk(ale_gap, 4);
		chk(tick_gap, 12);
		do cyc(1); while (cyc_end !== 1'b1);
		chk(ale, 1'b0);
		cyc(1);
		chk(ale, 1'b1);
		chk(cyc_end, 1'b0);
		apb(1, `MCC_OFF_CTRL, 32'h4);
		cyc(40);
		chk(tick_gap, 4);
	endtask
	task automatic t_mul;
		apb(1, `MCC_OFF_CTRL, 32'h8);
		cyc(2);
		chk(clk_mul, 2'h1);
		apb(1, `MCC_OFF_CTRL, 32'h10);
		cyc(2);
		chk(clk_mul, 2'h2);
	endtask
	task automatic t_slow;
		apb(1, `MCC_OFF_CTRL, 32'h3);
		cyc(2100);
		chk(ale_gap, 1024);
		apb(0, `MCC_OFF_STAT, 32'h0);
		chk(r[0], 1'b1);
		ext_int <= 1'b1;
		cyc(20);
		ext_int <= 1'b0;
		cyc(1100);
		chk(ale_gap, 4);
		apb(0, `MCC_OFF_IRQ_STAT, 32'h0);
		chk(r[1], 1'b1);
		chk(irq, 1'b0);
		apb(1, `MCC_OFF_IRQ_EN, 32'h2);
		cyc(2);
		chk(irq, 1'b1);
		apb(1, `MCC_OFF_IRQ_CLR, 32'h2);
		cyc(2);
		chk(irq, 1'b0);
	endtask
	task automatic t_power;
		apb(1, `MCC_OFF_CTRL, 32'h20);
		cyc(8);
		chk(cpu_idle, 1'b1);
		wake <= 1'b1;
		cyc(6);
		wake <= 1'b0;
		cyc(6);
		chk(cpu_idle, 1'b0);
		apb(1, `MCC_OFF_CTRL, 32'h40);
		cyc(8);
		chk(clk_stop, 1'b1);
		serial_act <= 1'b1;
		cyc(6);
		serial_act <= 1'b0;
		cyc(6);
		chk(clk_stop, 1'b0);
	endtask
	task automatic t_fail;
		apb(0, 12'h100, 32'h0);
		chk(e, 1'b1);
		apb(1, `MCC_OFF_STAT, 32'h1);
		chk(e, 1'b1);
		supply_low <= 1'b1;
		cyc(10);
		apb(0, `MCC_OFF_IRQ_STAT, 32'h0);
		chk(r[0], 1'b1);
		chk(pf_reset, 1'b0);
		apb(1, `MCC_OFF_IRQ_EN, 32'h1);
		cyc(2);
		chk(irq, 1'b1);
		apb(1, `MCC_OFF_CTRL, 32'h80);
		cyc(4);
		chk(pf_reset, 1'b1);
	endtask
	task automatic t_reset;
		resetn <= 1'b0;
		cyc(2);
		chk(ale, 1'b0);
		chk(pready, 1'b0);
		resetn <= 1'b1;
		cyc(1);
		apb(0, `MCC_OFF_CTRL, 32'h0);
		chk(r, `MCC_CTRL_RST);
		chk(pf_reset, 1'b0);
		chk(irq, 1'b0);
		chk(clk_mul, 2'h0);
		cyc(40);
		chk(ale_gap, 4);
		chk(tick_gap, 12);
	endtask
	initial begin
		cyc(16);
		resetn <= 1'b1;
		cyc(1);
		t_default();
		t_mul();
		t_slow();
		t_power();
		t_fail();
		t_reset();
		report_and_stop();
	end
endmodule
